// ---- hw/otflm_map.vh ----
// Constants for the over-temperature fault limit monitor.
// Assumes the includer uses them with matching widths.
`ifndef OTFLM_MAP_VH
`define OTFLM_MAP_VH
`define OTFLM_CMD_FAULT_LIMIT  8'h4f
`define OTFLM_PAGE_CH1         8'h00
`define OTFLM_PAGE_CH2         8'h01
`define OTFLM_PAGE_BOTH        8'h11
`define OTFLM_LIMIT_RESET      16'h0091
`define OTFLM_LIMIT_MIN        11'h078
`define OTFLM_LIMIT_MAX        11'h0a5
`define OTFLM_HYST             11'h014
`define OTFLM_MANT_W           11
`define OTFLM_TEMP_FAULT_BIT   7
`define OTFLM_TEMP_WARN_BIT    6
`define OTFLM_BYTE_TEMP_FAULT_OR_WARN_SUMMARY_BIT    2
`define OTFLM_BYTE_CML_BIT     1
`define OTFLM_CML_IVC_BIT      7
`define OTFLM_CML_IVD_BIT      6
`endif

// ---- hw/otflm_chan_det.v ----
// One channel's over-temperature detector with hysteresis.
// Assumes temperature and limit are 11-bit two's complement degrees C.
`default_nettype none
module otflm_chan_det #(
  parameter W = 11
) (
  input  wire         core_clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] temp_i,
  input  wire [W-1:0] limit_i,
  input  wire [W-1:0] hyst_i,
  output wire         fault_o
);
  reg          fault_q;
  wire [W-1:0] release_lvl;
  assign release_lvl = limit_i - hyst_i;
  always @(posedge core_clk_i)
  begin
    if (!nrst_i)
      fault_q <= 1'b0;
    else if ($signed(temp_i) > $signed(limit_i))
      fault_q <= 1'b1;
    else if ($signed(temp_i) <= $signed(release_lvl))
      fault_q <= 1'b0;
  end
  assign fault_o = fault_q;
endmodule
`default_nettype wire

// ---- hw/otflm_top.v ----
// Over-temperature fault limit, detectors and status for two channels.
// Assumes a PMBus front end delivers decoded word writes and clears,
// and that temperatures arrive from another clock domain.
`include "otflm_map.vh"
`default_nettype none
// Function
// - Fault when temperature exceeds channel limit
// - Fault sets fault, warning and summary flags
// - Fault asserts alert output
// - Fault raises per-channel thermal shutdown
// - Page 0 channel 1, page 1 channel 2
// - Page 11 writes both channels
// - Channel 2 writable only as master
// - Slave channel 2 uses channel 1 limit
// - Slave channel 2 write NACKs, INVALID_COMMAND_FAULT, alert
// - Limit not above warning flags invalid data
// - Power-up limit 145 unless stored value
// - Exponent reads zero, writes ignored
// - Mantissa range 120 to 165 degrees
// - One degree resolution
// - Release 20 degrees below limit
// - Reached via command 4Fh word
module otflm_top (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire        wr_stb_i,
  input  wire [7:0]  wr_cmd_i,
  input  wire [7:0]  page_i,
  input  wire [15:0] wr_data_i,
  input  wire [7:0]  rd_cmd_i,
  output wire [15:0] rd_data_o,
  output wire        wr_nack_o,
  input  wire        ch2_master_i,
  input  wire        nvm_valid_i,
  input  wire [15:0] nvm_limit_i,
  input  wire [10:0] warn_limit_ch1_i,
  input  wire [10:0] warn_limit_ch2_i,
  input  wire [10:0] temp_ch1_i,
  input  wire [10:0] temp_ch2_i,
  input  wire        clr_temp_i,
  input  wire        clr_cml_i,
  output wire [7:0]  status_temp_ch1_o,
  output wire [7:0]  status_temp_ch2_o,
  output wire [7:0]  status_byte_o,
  output wire [15:0] status_word_o,
  output wire [7:0]  status_cml_o,
  output wire        smb_alert_n_o,
  output wire [1:0]  channel_thermal_shutdown_o
);
  // ==========================================================
  // Input synchronisers
  reg  [10:0] t1_s1_q, t1_s2_q, t2_s1_q, t2_s2_q;
  always @(posedge core_clk_i)
  begin
    t1_s1_q <= temp_ch1_i;
    t1_s2_q <= t1_s1_q;
    t2_s1_q <= temp_ch2_i;
    t2_s2_q <= t2_s1_q;
  end
  // Multi-bit sync is safe only for slow, settled sensor words

  // ==========================================================
  // Limit registers
  reg  [10:0] lim1_q, lim2_q;
  reg         loaded_q;
  wire        is_cmd = wr_stb_i && (wr_cmd_i == `OTFLM_CMD_FAULT_LIMIT);
  wire        pg1    = page_i == `OTFLM_PAGE_CH1;
  wire        pg2    = page_i == `OTFLM_PAGE_CH2;
  wire        pgb    = page_i == `OTFLM_PAGE_BOTH;
  wire [10:0] wmant  = wr_data_i[10:0];
  wire        rng_ok = ($signed(wmant) >= $signed(`OTFLM_LIMIT_MIN)) &&
                       ($signed(wmant) <= $signed(`OTFLM_LIMIT_MAX));
  wire        w1_ok  = $signed(wmant) > $signed(warn_limit_ch1_i);
  wire        w2_ok  = $signed(wmant) > $signed(warn_limit_ch2_i);
  wire        slave_hit = is_cmd && (pg2 || pgb) && !ch2_master_i;
  wire        warn_bad  = is_cmd && !slave_hit && (pg1 || pg2 || pgb) &&
                          (!rng_ok ||
                           ((pg1 || pgb) && !w1_ok) ||
                           ((pg2 || pgb) && !w2_ok));
  wire        do_wr  = is_cmd && !slave_hit && !warn_bad;
  // Full reset word kept whole; only the mantissa is stored
  wire [15:0] lim_rst = `OTFLM_LIMIT_RESET;
  assign wr_nack_o = slave_hit;

  always @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      lim1_q   <= lim_rst[10:0];
      lim2_q   <= lim_rst[10:0];
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      loaded_q <= 1'b1;
      if (nvm_valid_i)
      begin
        lim1_q <= nvm_limit_i[10:0];
        lim2_q <= nvm_limit_i[10:0];
      end
    end
    else if (do_wr)
    begin
      if (pg1 || pgb)
        lim1_q <= wmant;
      if (pg2 || pgb)
        lim2_q <= wmant;
    end
  end

  // Slave channel 2 follows channel 1; stored value kept for master
  wire [10:0] lim2_eff = ch2_master_i ? lim2_q : lim1_q;

  // ==========================================================
  // Detectors
  wire f1, f2;
  otflm_chan_det #(.W(`OTFLM_MANT_W)) u_det1 (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .temp_i     (t1_s2_q),
    .limit_i    (lim1_q),
    .hyst_i     (`OTFLM_HYST),
    .fault_o    (f1)
  );
  otflm_chan_det #(.W(`OTFLM_MANT_W)) u_det2 (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .temp_i     (t2_s2_q),
    .limit_i    (lim2_eff),
    .hyst_i     (`OTFLM_HYST),
    .fault_o    (f2)
  );
  assign channel_thermal_shutdown_o = {f2, f1};

  // ==========================================================
  // Sticky status, set wins over clear
  reg [1:0] otf_q, otw_q;
  reg       ivc_q, ivd_q;
  always @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      otf_q <= 2'h0;
      otw_q <= 2'h0;
      ivc_q <= 1'b0;
      ivd_q <= 1'b0;
    end
    else
    begin
      otf_q <= ({f2, f1}) | (clr_temp_i ? 2'h0 : otf_q);
      otw_q <= ({f2, f1}) | (clr_temp_i ? 2'h0 : otw_q);
      ivc_q <= slave_hit | (!clr_cml_i & ivc_q);
      ivd_q <= warn_bad | (!clr_cml_i & ivd_q);
    end
  end

  assign status_temp_ch1_o = {otf_q[0], otw_q[0], 6'h00};
  assign status_temp_ch2_o = {otf_q[1], otw_q[1], 6'h00};
  assign status_cml_o      = {ivc_q, ivd_q, 6'h00};
  wire temp_fault_or_warn_summary = |otf_q | |otw_q;
  wire cml  = ivc_q | ivd_q;
  assign status_byte_o = {5'h00, temp_fault_or_warn_summary, cml, 1'b0};
  assign status_word_o = {8'h00, status_byte_o};
  assign smb_alert_n_o = !(temp_fault_or_warn_summary | cml);

  // ==========================================================
  // Readback of paged limit, exponent reads zero
  reg [15:0] rd_q;
  always @(posedge core_clk_i)
  begin
    if (!nrst_i)
      rd_q <= 16'h0000;
    else if (rd_cmd_i == `OTFLM_CMD_FAULT_LIMIT)
      rd_q <= {5'h00, (pg2 ? lim2_eff : lim1_q)};
    else
      rd_q <= 16'h0000;
  end
  assign rd_data_o = rd_q;
endmodule
`default_nettype wire

// ---- dv/otflm_host.sv ----
// Host model: issues fault limit word writes and reads.
// Assumes the block samples everything on rising clk_i.
`default_nettype none
module otflm_host (
  input  wire logic        clk_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        nack_i,
  output var  logic        wr_stb_o,
  output var  logic [7:0]  cmd_o,
  output var  logic [7:0]  page_o,
  output var  logic [15:0] wr_data_o,
  output var  logic [7:0]  rd_cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {wr_stb_o, cmd_o, page_o, wr_data_o, rd_cmd_o} = '0;
  // Stacked slave limits are kept equal by the block; the host writes only what it is given
  task automatic wr(input logic [7:0] p, input logic [15:0] d,
                    output logic n);
    @(posedge clk_i) #5;
    {wr_stb_o, cmd_o, page_o, wr_data_o} = {1'b1, 8'h4f, p, d};
    #1 n = nack_i;
    // Released data shows its inverse, never the stale word
    @(posedge clk_i) #5 wr_stb_o = 1'b0;
    wr_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    @(posedge clk_i) #5;
    {rd_cmd_o, page_o} = {8'h4f, p};
    @(posedge clk_i) #5 d = rd_data_i;
    rd_cmd_o = 8'h00;
  endtask
endmodule
`default_nettype wire

// ---- dv/otflm_assertions.sv ----
// Checker on the monitor's write, status and shutdown ports.
// Assumes one clock and synchronous active-low reset.
`default_nettype none
module otflm_assertions (
  input wire core_clk_i, nrst_i, wr_stb_i, ch2_master_i, clr_temp_i,
  input wire [7:0] wr_cmd_i, page_i, status_temp_ch1_o, status_byte_o,
  input wire [7:0] status_cml_o,
  input wire [15:0] rd_data_o, status_word_o,
  input wire wr_nack_o, smb_alert_n_o,
  input wire [1:0] channel_thermal_shutdown_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire slv_wr = wr_stb_i && wr_cmd_i == 8'h4f && !ch2_master_i &&
                (page_i == 8'h01 || page_i == 8'h11);
  // ==========================================
  // Assertions
  slave_nack_a: assert property (slv_wr |-> wr_nack_o)
    else $error("slave write not refused");
  slave_ivc_a: assert property (slv_wr |=> status_cml_o[7])
    else $error("slave write left no fault");
  alert_low_a: assert property ((|status_cml_o[7:6] ||
    status_temp_ch1_o[7]) |-> !smb_alert_n_o) else $error("alert idle");
  flag_pair_a: assert property (status_temp_ch1_o[7] |->
    status_temp_ch1_o[6] && status_byte_o[2]) else $error("flags");
  word_copy_a: assert property (status_word_o == {8'h00, status_byte_o})
    else $error("word status differs");
  cml_sum_a: assert property (status_cml_o[6] |-> status_byte_o[1])
    else $error("cml summary missing");
  // Flag lands one edge after the shutdown register rises
  sd_flag_a: assert property ($rose(channel_thermal_shutdown_o[0]) |=>
    status_temp_ch1_o[7]) else $error("shutdown without flag");
  flag_hold_a: assert property (status_temp_ch1_o[7] && !clr_temp_i |=>
    status_temp_ch1_o[7]) else $error("flag lost");
  exp_zero_a: assert property (rd_data_o[15:11] == 5'h00)
    else $error("exponent not zero");
  slv_c: cover property (slv_wr);
  sd_c: cover property (channel_thermal_shutdown_o == 2'b01);
  ivd_c: cover property (status_cml_o[6]);
endmodule
bind otflm_top otflm_assertions u_chk (.*);
`default_nettype wire

// ---- dv/test_overtemp_fault_limit_monitor.sv ----
// Bench: limit writes and reads, refusals, fault set and release.
// Assumes host model and checker are compiled before this file.
`default_nettype none
module test_overtemp_fault_limit_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, m2 = 1, clr_t = 0, clr_c = 0, n, stb, nk, al;
  logic [7:0] pg, cmd, rc, st1, st2, sb, sc;
  logic [15:0] wd, rdd, sw, d;
  logic [10:0] t1 = 11'h000, t2 = 11'h000;
  logic [1:0] sd;
  int bad_count = 0, checked = 0, cyc = 0;
  otflm_host h (.clk_i(clk), .rd_data_i(rdd), .nack_i(nk), .wr_stb_o(stb),
    .cmd_o(cmd), .page_o(pg), .wr_data_o(wd), .rd_cmd_o(rc));
  otflm_top dut (.core_clk_i(clk), .nrst_i(nrst), .wr_stb_i(stb),
    .wr_cmd_i(cmd), .page_i(pg), .wr_data_i(wd), .rd_cmd_i(rc),
    .rd_data_o(rdd), .wr_nack_o(nk), .ch2_master_i(m2), .nvm_valid_i(1'b0),
    .nvm_limit_i(16'h0000), .warn_limit_ch1_i(11'h07d),
    .warn_limit_ch2_i(11'h07d), .temp_ch1_i(t1), .temp_ch2_i(t2),
    .clr_temp_i(clr_t), .clr_cml_i(clr_c), .status_temp_ch1_o(st1),
    .status_temp_ch2_o(st2), .status_byte_o(sb), .status_word_o(sw),
    .status_cml_o(sc), .smb_alert_n_o(al),
    .channel_thermal_shutdown_o(sd));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin bad_count++; close_out; end
  task automatic chk(input logic [15:0] g, e);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    h.rd(p, d);
    chk(d, e);
  endtask
  task automatic clr_all;
    @(posedge clk) #5 {clr_t, clr_c} = 2'b11;
    @(posedge clk) #5 {clr_t, clr_c} = 2'b00;
  endtask
  task automatic temp(input logic [10:0] a, b);
    {t1, t2} = {a, b};
    repeat (4) @(posedge clk);
    #5;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (12) @(posedge clk);
    #5 nrst = 1;
    repeat (2) @(posedge clk);
    rd(8'h00, 16'h0091);
    h.wr(8'h11, 16'hf896, n); chk(n, 0);
    rd(8'h00, 16'h0096); rd(8'h01, 16'h0096);
    h.wr(8'h01, 16'h0082, n); rd(8'h01, 16'h0082);
    rd(8'h00, 16'h0096);
    h.wr(8'h00, 16'h007d, n); chk({sc[6], sb[1], al}, 3'b110);
    clr_all; chk(al, 1);
    h.wr(8'h00, 16'h00a6, n); chk(sc[6], 1);
    h.wr(8'h00, 16'h00a5, n); rd(8'h00, 16'h00a5);
    clr_all; m2 = 0;
    h.wr(8'h01, 16'h0080, n); chk({n, sc[7], al}, 3'b110);
    rd(8'h01, 16'h00a5);
    h.wr(8'h11, 16'h00a5, n); chk(n, 1);
    clr_all; m2 = 1;
    h.wr(8'h11, 16'h007e, n); chk(sc, 0);
    temp(11'd127, 11'd0); chk({sd, st1[7:6], sb[2], al}, 6'b011110);
    chk(sw, 16'h0004);
    temp(11'd107, 11'd0); chk(sd, 2'b01);
    temp(11'd106, 11'd0); chk({sd, st1[7]}, 3'b001);
    clr_all; chk({st1[7], al}, 2'b01);
    temp(11'd0, 11'd127); chk({sd, st2[7]}, 3'b101);
    close_out;
  end
endmodule
`default_nettype wire
